// file: src/pfs_pkg.sv
package pfs_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] PFS_CTRL_OFF   = 8'h00;
  localparam logic [7:0] PFS_STAT_OFF   = 8'h04;
  localparam logic [7:0] PFS_IRQ_OFF    = 8'h08;
  localparam logic [7:0] PFS_MASK_OFF   = 8'h0C;
  localparam logic [7:0] PFS_SENSE_OFF  = 8'h10;
  localparam logic [7:0] PFS_SINC_OFF   = 8'h14;

  // ==========================================================
  // Control field positions
  // ==========================================================
  localparam int PFS_SEL_LSB   = 0;
  localparam int PFS_LOCK_BIT  = 4;
  localparam int PFS_RPT_LSB   = 8;
  localparam int PFS_PSI5_BIT  = 12;

  // ==========================================================
  // Self-test select codes and values
  // ==========================================================
  localparam logic [3:0]  PFS_SEL_NONE = 4'h0;
  localparam logic [3:0]  PFS_SEL_CM   = 4'h1;
  localparam logic [15:0] PFS_FIX0 = 16'h0000;
  localparam logic [15:0] PFS_FIX1 = 16'hAAAA;
  localparam logic [15:0] PFS_FIX2 = 16'h5555;
  localparam logic [15:0] PFS_FIX3 = 16'hFFFF;
  localparam logic [22:0] PFS_DIG0 = 23'h008171;
  localparam logic [22:0] PFS_DIG1 = 23'h006C95;
  localparam logic [22:0] PFS_DIG2 = 23'h00807A;
  localparam logic [22:0] PFS_DIG3 = 23'h0078AC;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int PFS_CLK_MHZ      = 125;
  localparam int PFS_MOD_MHZ      = 1;
  localparam int PFS_MOD_DIV      = PFS_CLK_MHZ / PFS_MOD_MHZ;
  localparam int PFS_DEC_RATIO    = 48;
  localparam int PFS_START_US     = 1000;
  localparam int PFS_ITER_US      = 500;
  localparam int PFS_P0INIT_US    = 1000;
  localparam int PFS_START_CYC    = PFS_START_US * PFS_CLK_MHZ;
  localparam int PFS_ITER_CYC     = PFS_ITER_US * PFS_CLK_MHZ;
  localparam int PFS_P0INIT_CYC   = PFS_P0INIT_US * PFS_CLK_MHZ;
  localparam logic [3:0] PFS_RPT_RST = 4'h3;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic        psi5_mode;
    logic [3:0]  retry_limit;
    logic        lock;
    logic [3:0]  sel;
  } pfs_ctrl_t;

  typedef enum logic [2:0] {
    PFS_IRQ_SAMPLE, PFS_IRQ_PASS, PFS_IRQ_FAIL
  } pfs_irq_bit_t;

endpackage

// file: src/pfs_sinc3.sv
`timescale 1ns/1ps
module pfs_sinc3
  import pfs_pkg::*;
(
  input  wire logic               ref_clk_in,
  input  wire logic               reset_n_in,
  input  wire logic               mod_en_in,
  input  wire logic               bit_in,
  output logic signed [22:0]      word_out,
  output logic                    valid_out
);

  // ==========================================================
  // Integrators at modulator rate, combs at decimated rate
  // ==========================================================
  logic signed [22:0] int_q [3];
  logic signed [22:0] int_d [3];
  logic signed [22:0] cmb_q [3];
  logic signed [22:0] cmb_d [3];
  logic        [5:0]  cnt_q, cnt_d;
  logic signed [22:0] word_d, c0, c1, c2;
  logic               valid_d;
  logic signed [22:0] x;

  always_comb begin
    x = bit_in ? 23'sh000001 : -23'sh000001;
    int_d = int_q;
    cmb_d = cmb_q;
    cnt_d = cnt_q;
    word_d = word_out;
    valid_d = 1'b0;
    c0 = int_q[2] - cmb_q[0];
    c1 = c0 - cmb_q[1];
    c2 = c1 - cmb_q[2];
    if (mod_en_in) begin
      int_d[0] = int_q[0] + x;
      int_d[1] = int_q[1] + int_q[0];
      int_d[2] = int_q[2] + int_q[1];
      if (cnt_q == 6'(PFS_DEC_RATIO - 1)) begin
        cnt_d = 6'h00;
        cmb_d[0] = int_q[2];
        cmb_d[1] = c0;
        cmb_d[2] = c1;
        word_d = c2;
        valid_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 3; i++) begin
        int_q[i] <= '0;
        cmb_q[i] <= '0;
      end
      cnt_q <= '0;
      word_out <= '0;
      valid_out <= 1'b0;
    end else begin
      int_q <= int_d;
      cmb_q <= cmb_d;
      cnt_q <= cnt_d;
      word_out <= word_d;
      valid_out <= valid_d;
    end
  end

endmodule

// file: src/pfs_front_end.sv
// Behaviour
// - Fixed codes 4..7 force sense results
// - Fixed codes keep running flag set
// - Fixed codes accepted only before lock
// - PSI5 mode runs auto self-test after delay
// - Iteration timed; retry up to limit
// - Running flag clears on pass or limit
// - Fail flag cleared on pass, set on fail
// - Final fail sets error message output; sense data continues
// - Auto-test fail flag cleared only by reset
// - After test, restart baseline init phase
// - Second-order bitstream at 1 MHz, two-sample delay
// - Third-order sinc, ratio 48
// - Lock forces select zero, blocks select writes
// - Codes 12..15 substitute sinc output values
`timescale 1ns/1ps
module pfs_front_end
  import pfs_pkg::*;
#(
  parameter int START_CYC  = PFS_START_CYC,
  parameter int ITER_CYC   = PFS_ITER_CYC,
  parameter int P0INIT_CYC = PFS_P0INIT_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mod_bit_in,
  input  wire logic        cm_fail_in,
  output logic             mod_clk_out,
  output logic [15:0]      sense_out,
  output logic             selftest_fail_flag_msg_out,
  output logic             baseline_init_out,
  output logic             irq_out
);

  // ==========================================================
  // Decoding
  // ==========================================================
  function automatic logic is_fixed(input logic [3:0] s);
    return s[3:2] == 2'b01;
  endfunction

  function automatic logic is_digital(input logic [3:0] s);
    return s[3:2] == 2'b11;
  endfunction

  // ==========================================================
  // Modulator rate divider and pin sync
  // ==========================================================
  logic [6:0] div_q, div_d;
  logic       mod_en_q, mod_en_d;
  logic       mclk_q, mclk_d;
  logic [1:0] bit_sync_q;
  logic [1:0] cm_sync_q;

  always_comb begin
    div_d = div_q + 7'h01;
    mod_en_d = 1'b0;
    if (div_q == 7'(PFS_MOD_DIV - 1)) begin
      div_d = 7'h00;
      mod_en_d = 1'b1;
    end
    mclk_d = (div_q < 7'(PFS_MOD_DIV / 2));
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      div_q <= '0;
      mod_en_q <= 1'b0;
      mclk_q <= 1'b0;
      bit_sync_q <= '0;
      cm_sync_q <= '0;
    end else begin
      div_q <= div_d;
      mod_en_q <= mod_en_d;
      mclk_q <= mclk_d;
      bit_sync_q <= {bit_sync_q[0], mod_bit_in};
      cm_sync_q <= {cm_sync_q[0], cm_fail_in};
    end
  end

  assign mod_clk_out = mclk_q;

  // ==========================================================
  // Decimation
  // ==========================================================
  logic signed [22:0] sinc_word;
  logic               sinc_valid;

  pfs_sinc3 u_sinc (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .mod_en_in  (mod_en_q),
    .bit_in     (bit_sync_q[1]),
    .word_out   (sinc_word),
    .valid_out  (sinc_valid)
  );

  // ==========================================================
  // Self-test sequencer
  // ==========================================================
  typedef enum logic [2:0] {
    ST_WAIT, ST_ITER, ST_P0INIT, ST_DONE
  } pfs_st_t;

  pfs_st_t        st_q, st_d;
  logic [31:0]    tmr_q, tmr_d;
  logic [3:0]     tries_q, tries_d;
  logic           iter_fail_q, iter_fail_d;
  logic           auto_run_q, auto_run_d;
  logic           fail_q, fail_d;
  logic           fail_lock_q, fail_lock_d;
  logic           msg_q, msg_d;
  logic           p0_q, p0_d;
  logic           ev_pass, ev_fail;
  pfs_ctrl_t      ctrl_q, ctrl_d;
  logic [22:0]    dig_val;

  always_comb begin
    case (ctrl_q.sel[1:0])
      2'd0:    dig_val = PFS_DIG0;
      2'd1:    dig_val = PFS_DIG1;
      2'd2:    dig_val = PFS_DIG2;
      default: dig_val = PFS_DIG3;
    endcase
  end

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    tries_d = tries_q;
    iter_fail_d = iter_fail_q;
    auto_run_d = auto_run_q;
    fail_d = fail_q;
    fail_lock_d = fail_lock_q;
    msg_d = msg_q;
    p0_d = p0_q;
    ev_pass = 1'b0;
    ev_fail = 1'b0;
    case (st_q)
      ST_WAIT: begin
        if (tmr_q >= 32'(START_CYC - 1)) begin
          st_d = ctrl_q.psi5_mode ? ST_ITER : ST_DONE;
          tmr_d = '0;
          auto_run_d = ctrl_q.psi5_mode;
          iter_fail_d = 1'b0;
        end else begin
          tmr_d = tmr_q + 32'h1;
        end
      end
      ST_ITER: begin
        if (cm_sync_q[1]) begin
          iter_fail_d = 1'b1;
        end
        if (tmr_q >= 32'(ITER_CYC - 1)) begin
          tmr_d = '0;
          if (!iter_fail_d) begin
            auto_run_d = 1'b0;
            fail_d = fail_lock_q;
            ev_pass = 1'b1;
            st_d = ST_P0INIT;
            p0_d = 1'b1;
          end else if (tries_q >= ctrl_q.retry_limit) begin
            auto_run_d = 1'b0;
            fail_d = 1'b1;
            fail_lock_d = 1'b1;
            msg_d = 1'b1;
            ev_fail = 1'b1;
            st_d = ST_P0INIT;
            p0_d = 1'b1;
          end else begin
            tries_d = tries_q + 4'h1;
            iter_fail_d = 1'b0;
          end
        end else begin
          tmr_d = tmr_q + 32'h1;
        end
      end
      ST_P0INIT: begin
        if (tmr_q >= 32'(P0INIT_CYC - 1)) begin
          p0_d = 1'b0;
          st_d = ST_DONE;
        end else begin
          tmr_d = tmr_q + 32'h1;
        end
      end
      ST_DONE: st_d = ST_DONE;
      default: st_d = ST_DONE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      st_q <= ST_WAIT;
      tmr_q <= '0;
      tries_q <= '0;
      iter_fail_q <= 1'b0;
      auto_run_q <= 1'b0;
      fail_q <= 1'b0;
      fail_lock_q <= 1'b0;
      msg_q <= 1'b0;
      p0_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      tries_q <= tries_d;
      iter_fail_q <= iter_fail_d;
      auto_run_q <= auto_run_d;
      fail_q <= fail_d;
      fail_lock_q <= fail_lock_d;
      msg_q <= msg_d;
      p0_q <= p0_d;
    end
  end

  // ==========================================================
  // Sense result path
  // ==========================================================
  logic [15:0] sense_q, sense_d;
  logic [22:0] sinc_q, sinc_d;
  logic        run_flag;

  assign run_flag = auto_run_q || is_fixed(ctrl_q.sel);

  always_comb begin
    sense_d = sense_q;
    sinc_d = sinc_q;
    if (is_fixed(ctrl_q.sel)) begin
      case (ctrl_q.sel[1:0])
        2'd0:    sense_d = PFS_FIX0;
        2'd1:    sense_d = PFS_FIX1;
        2'd2:    sense_d = PFS_FIX2;
        default: sense_d = PFS_FIX3;
      endcase
    end else if (sinc_valid) begin
      sinc_d = is_digital(ctrl_q.sel) ? dig_val : sinc_word;
      sense_d = is_digital(ctrl_q.sel) ? dig_val[15:0]
                                       : sinc_word[22:7];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      sense_q <= '0;
      sinc_q <= '0;
    end else begin
      sense_q <= sense_d;
      sinc_q <= sinc_d;
    end
  end

  // ==========================================================
  // APB registers and interrupts
  // ==========================================================
  logic [2:0]  irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
  logic [31:0] rdata_d;
  logic        rdy_d, err_d, irq_d, wr, rd_ok;
  logic [2:0]  ev;

  assign ev = {ev_fail, ev_pass, sinc_valid};
  assign wr = psel && penable && pwrite && pready;

  always_comb begin
    ctrl_d = ctrl_q;
    irq_st_d = irq_st_q;
    irq_mask_d = irq_mask_q;
    rdy_d = psel && penable && !pready;
    rd_ok = paddr inside {PFS_CTRL_OFF, PFS_STAT_OFF, PFS_IRQ_OFF,
                          PFS_MASK_OFF, PFS_SENSE_OFF, PFS_SINC_OFF};
    err_d = rdy_d && !rd_ok;
    rdata_d = prdata;
    if (wr && paddr == PFS_CTRL_OFF) begin
      ctrl_d.psi5_mode = pwdata[PFS_PSI5_BIT];
      ctrl_d.retry_limit = pwdata[PFS_RPT_LSB +: 4];
      ctrl_d.lock = ctrl_q.lock | pwdata[PFS_LOCK_BIT];
      if (!ctrl_q.lock && !pwdata[PFS_LOCK_BIT]) begin
        ctrl_d.sel = pwdata[PFS_SEL_LSB +: 4];
      end
    end
    if (ctrl_d.lock) begin
      ctrl_d.sel = PFS_SEL_NONE;
    end
    if (wr && paddr == PFS_IRQ_OFF) begin
      irq_st_d = irq_st_q & ~pwdata[2:0];
    end
    if (wr && paddr == PFS_MASK_OFF) begin
      irq_mask_d = pwdata[2:0];
    end
    irq_st_d = irq_st_d | ev;
    if (rdy_d && !pwrite) begin
      case (paddr)
        PFS_CTRL_OFF:  rdata_d = {19'h0, ctrl_q[9:5], 3'h0, ctrl_q[4:0]};
        PFS_STAT_OFF:  rdata_d = {26'h0, p0_q, msg_q, fail_q,
                                  run_flag, tries_q[1:0]};
        PFS_IRQ_OFF:   rdata_d = {29'h0, irq_st_q};
        PFS_MASK_OFF:  rdata_d = {29'h0, irq_mask_q};
        PFS_SENSE_OFF: rdata_d = {16'h0, sense_q};
        PFS_SINC_OFF:  rdata_d = {9'h0, sinc_q};
        default:       rdata_d = 32'h0;
      endcase
    end
    irq_d = |(irq_st_q & irq_mask_q);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ctrl_q <= '{psi5_mode: 1'b0, retry_limit: PFS_RPT_RST,
                  lock: 1'b0, sel: PFS_SEL_NONE};
      irq_st_q <= '0;
      irq_mask_q <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      prdata <= rdata_d;
      pready <= rdy_d;
      pslverr <= err_d;
      irq_out <= irq_d;
    end
  end

  assign sense_out = sense_q;
  assign selftest_fail_flag_msg_out = msg_q;
  assign baseline_init_out = p0_q;

endmodule

// file: tb/pfs_front_end_monitor.sv
`timescale 1ns/1ps
module pfs_front_end_monitor
  import pfs_pkg::*;
#(
  parameter int P0INIT_CYC = PFS_P0INIT_CYC
) (
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mod_clk_out,
  input wire logic [15:0] sense_out,
  input wire logic        selftest_fail_flag_msg_out,
  input wire logic        baseline_init_out
);
  // ==========================================================
  // Helper counters
  // ==========================================================
  logic       mc_q;
  logic       seen_q;
  logic [7:0] mcnt_q;
  int         bcnt_q;
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      mc_q   <= 1'b0;
      seen_q <= 1'b0;
      mcnt_q <= 8'h00;
      bcnt_q <= 0;
    end else begin
      mc_q   <= mod_clk_out;
      if (mod_clk_out && !mc_q) begin
        mcnt_q <= 8'h00;
        seen_q <= 1'b1;
      end else begin
        mcnt_q <= mcnt_q + 8'h01;
      end
      bcnt_q <= baseline_init_out ? bcnt_q + 1 : 0;
    end
  end
  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not after one wait state");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  a_mod_clk_rate: assert property (mod_clk_out && !mc_q && seen_q |->
    mcnt_q == 8'(PFS_MOD_DIV - 1))
    else $error("modulator clock period wrong");
  a_err_msg_sticky: assert property (selftest_fail_flag_msg_out |=>
    selftest_fail_flag_msg_out)
    else $error("error message dropped");
  a_reset_clears: assert property (disable iff (1'b0) !reset_n_in |=>
    sense_out == 16'h0000 && !selftest_fail_flag_msg_out && !pready)
    else $error("outputs not cleared by reset");
  a_baseline_len: assert property ($fell(baseline_init_out) |->
    bcnt_q >= P0INIT_CYC - 2 && bcnt_q <= P0INIT_CYC + 2)
    else $error("baseline init length wrong");
  c_slverr: cover property (pslverr);
  c_err_msg: cover property ($rose(selftest_fail_flag_msg_out));
  c_baseline: cover property ($fell(baseline_init_out));
endmodule

bind pfs_front_end pfs_front_end_monitor #(.P0INIT_CYC(P0INIT_CYC)) u_mon (
  .ref_clk_in        (ref_clk_in),
  .reset_n_in        (reset_n_in),
  .psel              (psel),
  .penable           (penable),
  .pready            (pready),
  .pslverr           (pslverr),
  .mod_clk_out       (mod_clk_out),
  .sense_out         (sense_out),
  .selftest_fail_flag_msg_out  (selftest_fail_flag_msg_out),
  .baseline_init_out (baseline_init_out)
);

// file: tb/pfs_xducer_model.sv
`timescale 1ns/1ps
module pfs_xducer_model (
  input  wire logic mod_clk_in,
  input  wire logic fail_req_in,
  output logic      mod_bit_out,
  output logic      cm_fail_out
);
  real acc1 = 0.0;
  real acc2 = 0.0;
  real fb;
  initial mod_bit_out = 1'b0;
  assign cm_fail_out = fail_req_in;
  // ==========================================================
  // Second-order loop, one bit per modulator clock
  // ==========================================================
  always @(posedge mod_clk_in) begin
    fb = mod_bit_out ? 1.0 : -1.0;
    acc1 = acc1 + 0.25 - fb;
    acc2 = acc2 + acc1 - fb;
    mod_bit_out <= (acc2 >= 0.0);
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  num_errors++; $display("wrong value at %0t: got %0h exp %0h", \
  $time, a, b); end end
module tb_top
  import pfs_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        fail_req   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mod_bit;
  logic        cm_fail;
  logic        mod_clk;
  logic [15:0] sense;
  logic        err_msg;
  logic        bl_init;
  logic        irq_out;
  logic [31:0] rdata;
  logic        last_err;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          t0;
  logic [15:0] fx [4] = '{PFS_FIX0, PFS_FIX1, PFS_FIX2, PFS_FIX3};
  logic [15:0] dg [4] = '{PFS_DIG0[15:0], PFS_DIG1[15:0],
                          PFS_DIG2[15:0], PFS_DIG3[15:0]};
  always #4 ref_clk_in = ~ref_clk_in;
  pfs_front_end #(.START_CYC(50), .ITER_CYC(50), .P0INIT_CYC(50))
    u_pfs_front_end (
    .ref_clk_in (ref_clk_in), .reset_n_in (reset_n_in), .psel (psel),
    .penable (penable), .pwrite (pwrite), .paddr (paddr),
    .pwdata (pwdata), .prdata (prdata), .pready (pready),
    .pslverr (pslverr), .mod_bit_in (mod_bit), .cm_fail_in (cm_fail),
    .mod_clk_out (mod_clk), .sense_out (sense),
    .selftest_fail_flag_msg_out (err_msg), .baseline_init_out (bl_init),
    .irq_out (irq_out));
  pfs_xducer_model u_pfs_xducer_model (
    .mod_clk_in (mod_clk), .fail_req_in (fail_req),
    .mod_bit_out (mod_bit), .cm_fail_out (cm_fail));
  // ==========================================================
  // Bus tasks
  // ==========================================================
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in);
    while (pready !== 1'b1);
    rdata    = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic do_reset;
    reset_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    do begin rd(PFS_STAT_OFF); k++; end
    while (rdata[2] !== 1'b1 && k < 40);
    if (k >= 40) num_errors++;
    t0 = cyc;
    k = 0;
    do begin rd(PFS_STAT_OFF); k++; end
    while (rdata[2] !== 1'b0 && k < 200);
    if (k >= 200) num_errors++;
  endtask
  task automatic final_report;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc > 90000) begin
      num_errors++;
      final_report;
    end
  end
  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    do_reset;
    rd(PFS_CTRL_OFF);
    `CHK(rdata[12:0], 13'h0300)
    for (int i = 0; i < 4; i++) begin
      wr(PFS_CTRL_OFF, 32'h0304 + i);
      rd(PFS_SENSE_OFF);
      `CHK(rdata[15:0], fx[i])
      `CHK(sense, fx[i])
      rd(PFS_STAT_OFF);
      `CHK(rdata[2], 1'b1)
    end
    wr(PFS_IRQ_OFF, 32'h7);
    wr(PFS_CTRL_OFF, 32'h0300);
    repeat (12200) @(posedge ref_clk_in);
    `CHK(sense !== 16'hFFFF, 1'b1)
    rd(PFS_IRQ_OFF);
    `CHK(rdata[0], 1'b1)
    for (int i = 0; i < 4; i++) begin
      wr(PFS_CTRL_OFF, 32'h030C + i);
      repeat (12200) @(posedge ref_clk_in);
      `CHK(sense, dg[i])
    end
    rd(8'h20);
    `CHK({last_err, rdata}, 33'h1_0000_0000)
    wr(PFS_CTRL_OFF, 32'h0315);
    rd(PFS_CTRL_OFF);
    `CHK(rdata[4:0], 5'h10)
    wr(PFS_CTRL_OFF, 32'h0314);
    rd(PFS_CTRL_OFF);
    `CHK(rdata[4:0], 5'h10)
    fail_req <= 1'b1;
    do_reset;
    wr(PFS_CTRL_OFF, 32'h1300);
    wait_done;
    `CHK((cyc - t0) > 170 && (cyc - t0) < 215, 1'b1)
    `CHK(rdata[4:3], 2'b11)
    `CHK(err_msg, 1'b1)
    `CHK(bl_init, 1'b1)
    repeat (60) @(posedge ref_clk_in);
    `CHK(bl_init, 1'b0)
    wr(PFS_STAT_OFF, 32'hFFFFFFFF);
    wr(PFS_CTRL_OFF, 32'h0);
    rd(PFS_STAT_OFF);
    `CHK(rdata[3], 1'b1)
    `CHK(irq_out, 1'b0)
    wr(PFS_MASK_OFF, 32'h4);
    repeat (2) @(posedge ref_clk_in);
    `CHK(irq_out, 1'b1)
    wr(PFS_MASK_OFF, 32'h0);
    repeat (2) @(posedge ref_clk_in);
    `CHK(irq_out, 1'b0)
    wr(PFS_IRQ_OFF, 32'h7);
    rd(PFS_IRQ_OFF);
    `CHK(rdata[2:1], 2'b00)
    fail_req <= 1'b0;
    do_reset;
    wr(PFS_CTRL_OFF, 32'h1300);
    wait_done;
    `CHK((cyc - t0) < 65, 1'b1)
    `CHK(rdata[4:3], 2'b00)
    `CHK(err_msg, 1'b0)
    `CHK(bl_init, 1'b1)
    rd(PFS_IRQ_OFF);
    `CHK(rdata[1], 1'b1)
    final_report;
  end
endmodule
